/* src/panel_cmd_pkg.sv */
// constants for the panel command decoder
package panel_cmd_pkg;
    localparam logic [7:0] BLANK_PANEL_CMD = 8'h28;
    localparam logic [7:0] UNBLANK_PANEL_CMD = 8'h29;
    localparam logic [7:0] SCAN_ORIENTATION_CMD = 8'h36;
    localparam logic [7:0] WAKE_CMD = 8'h11;
    localparam logic [7:0] SOFT_RESET_CMD = 8'h01;
    localparam logic [7:0] SCAN_ORIENTATION_OFFSET = 8'h36;
    localparam logic [7:0] SCAN_ORIENTATION_RESET = 8'h00;
    localparam int FILTER_ORDER_BIT = 3;
    localparam int SOURCE_DIR_BIT = 1;
    localparam int GATE_DIR_BIT = 0;
    // bits that keep their value; the others read as zero
    localparam logic [7:0] SCAN_ORIENTATION_MASK = 8'h0b;
    localparam int CLK_HZ = 25000000;
    localparam int WAKE_TIME_MS = 120;
    localparam int WAKE_CYCLES = (CLK_HZ / 1000) * WAKE_TIME_MS;
    localparam int WAKE_BLANK_FRAMES = 2;
endpackage : panel_cmd_pkg

/* src/frame_sync_latch.sv */
// holds a setting and copies it to the output at frame start
module frame_sync_latch (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic frame_start_i,
    input wire logic [3:0] pending_i,
    output logic [3:0] active_o
);
    typedef struct packed {
        logic [3:0] active;
    } latch_state_t;

    latch_state_t state_reg;
    latch_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (frame_start_i) begin
            state_next.active = pending_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active_o = state_reg.active;
endmodule : frame_sync_latch

/* src/display_gate_and_scan_control.sv */
// command decoder for panel blanking and scan orientation
// Summary of operation
// - command 28h with no parameter blanks the panel output
// - blanking keeps incoming pixel data intact; blank page replaces output
// - on/off commands change only the on/off state
// - blank command while blanked does nothing
// - command 29h resumes driving the panel from pixel data
// - unblank command while unblanked does nothing
// - every reset leaves the panel blanked
// - command 36h with select low, then one parameter with select high
// - parameter bit 3 picks red-first (0) or blue-first (1) filter order
// - parameter bit 1 picks source scan direction
// - parameter bit 0 picks gate scan direction
// - parameter bits 7,6,5,4,2 have no function and stay zero
// - of the forced-zero bits, none stays writable here
// - after reset the device sleeps; wake takes 120 ms plus blank frames
module display_gate_and_scan_control #(
    parameter int WAKE_CYCLES = panel_cmd_pkg::WAKE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic byte_valid_i,
    input wire logic cmd_param_sel_i,
    input wire logic [7:0] byte_i,
    input wire logic frame_start_i,
    input wire logic [23:0] pixel_i,
    output logic [23:0] pixel_o,
    output logic blanked_o,
    output logic filter_order_sel_o,
    output logic source_dir_sel_o,
    output logic gate_dir_sel_o,
    output logic awake_o
);
    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_WAKING,
        ST_WAKE_BLANK,
        ST_AWAKE
    } power_t;

    typedef struct packed {
        power_t power;
        logic [31:0] wait_cnt;
        logic display_on;
        logic [7:0] scan_orientation_control_reg;
        logic expect_param;
        logic [23:0] pixel;
        logic blanked;
        logic awake;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;
    logic [3:0] pending;
    logic [3:0] active;
    logic cmd_seen;
    logic param_seen;

    function automatic logic [7:0] clean_param(input logic [7:0] raw);
        clean_param = raw & panel_cmd_pkg::SCAN_ORIENTATION_MASK;
    endfunction : clean_param

    assign cmd_seen = byte_valid_i && !cmd_param_sel_i;
    assign param_seen = byte_valid_i && cmd_param_sel_i;
    // pending: {display_on, filter, source, gate}
    assign pending = {state_reg.display_on,
        state_reg.scan_orientation_control_reg[panel_cmd_pkg::FILTER_ORDER_BIT],
        state_reg.scan_orientation_control_reg[panel_cmd_pkg::SOURCE_DIR_BIT],
        state_reg.scan_orientation_control_reg[panel_cmd_pkg::GATE_DIR_BIT]};

    frame_sync_latch u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .frame_start_i(frame_start_i),
        .pending_i(pending),
        .active_o(active)
    );

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        if (param_seen) begin
            state_next.expect_param = 1'b0;
        end
        if (param_seen && state_reg.expect_param) begin
            state_next.scan_orientation_control_reg =
                clean_param(byte_i);
        end
        if (cmd_seen) begin
            state_next.expect_param = 1'b0;
            case (byte_i)
                panel_cmd_pkg::BLANK_PANEL_CMD: begin
                    state_next.display_on = 1'b0;
                end
                panel_cmd_pkg::UNBLANK_PANEL_CMD: begin
                    state_next.display_on = 1'b1;
                end
                panel_cmd_pkg::SCAN_ORIENTATION_CMD: begin
                    state_next.expect_param = 1'b1;
                end
                panel_cmd_pkg::SOFT_RESET_CMD: begin
                    // scan parameter intentionally kept
                    state_next.display_on = 1'b0;
                    state_next.power = ST_SLEEP;
                end
                panel_cmd_pkg::WAKE_CMD: begin
                    if (state_reg.power == ST_SLEEP) begin
                        state_next.power = ST_WAKING;
                        state_next.wait_cnt = '0;
                    end
                end
                default: begin
                end
            endcase
        end
        // ----------------------------------------
        // wake sequence
        // ----------------------------------------
        case (state_reg.power)
            ST_WAKING: begin
                if (state_reg.wait_cnt == 32'(WAKE_CYCLES - 1)) begin
                    state_next.power = ST_WAKE_BLANK;
                    state_next.wait_cnt = '0;
                end else begin
                    state_next.wait_cnt = state_reg.wait_cnt + 32'h1;
                end
            end
            ST_WAKE_BLANK: begin
                if (frame_start_i) begin
                    if (state_reg.wait_cnt ==
                        32'(panel_cmd_pkg::WAKE_BLANK_FRAMES)) begin
                        state_next.power = ST_AWAKE;
                    end else begin
                        state_next.wait_cnt = state_reg.wait_cnt + 32'h1;
                    end
                end
            end
            ST_SLEEP, ST_AWAKE: begin
            end
            default: begin
                state_next.power = ST_SLEEP;
            end
        endcase
        if (cmd_seen && byte_i == panel_cmd_pkg::SOFT_RESET_CMD) begin
            state_next.power = ST_SLEEP;
        end
        // ----------------------------------------
        // pixel path
        // ----------------------------------------
        state_next.blanked = !(active[3] && state_reg.power == ST_AWAKE);
        state_next.pixel = state_next.blanked ? 24'h000000 : pixel_i;
        state_next.awake = (state_reg.power == ST_AWAKE);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg.power <= ST_SLEEP;
            state_reg.wait_cnt <= '0;
            state_reg.display_on <= 1'b0;
            state_reg.scan_orientation_control_reg <=
                panel_cmd_pkg::SCAN_ORIENTATION_RESET;
            state_reg.expect_param <= 1'b0;
            state_reg.pixel <= '0;
            state_reg.blanked <= 1'b1;
            state_reg.awake <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pixel_o = state_reg.pixel;
    assign blanked_o = state_reg.blanked;
    assign awake_o = state_reg.awake;
    assign filter_order_sel_o = active[2];
    assign source_dir_sel_o = active[1];
    assign gate_dir_sel_o = active[0];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_blank_cmd;
        @(posedge clk_i) disable iff (!rst_b_i)
        cmd_seen && byte_i == panel_cmd_pkg::BLANK_PANEL_CMD
        |=> !state_reg.display_on;
    endproperty
    a_blank_cmd: assert property (p_blank_cmd)
        else $error("blank command did not clear display state");

    property p_unblank_cmd;
        @(posedge clk_i) disable iff (!rst_b_i)
        cmd_seen && byte_i == panel_cmd_pkg::UNBLANK_PANEL_CMD
        |=> state_reg.display_on;
    endproperty
    a_unblank_cmd: assert property (p_unblank_cmd)
        else $error("unblank command did not set display state");

    property p_onoff_keeps_scan;
        @(posedge clk_i) disable iff (!rst_b_i)
        cmd_seen && (byte_i == panel_cmd_pkg::BLANK_PANEL_CMD ||
            byte_i == panel_cmd_pkg::UNBLANK_PANEL_CMD)
        |=> $stable(state_reg.scan_orientation_control_reg);
    endproperty
    a_onoff_keeps_scan: assert property (p_onoff_keeps_scan)
        else $error("on/off command changed scan setting");

    property p_param_store;
        @(posedge clk_i) disable iff (!rst_b_i)
        param_seen && state_reg.expect_param
        |=> state_reg.scan_orientation_control_reg ==
            ($past(byte_i) & panel_cmd_pkg::SCAN_ORIENTATION_MASK);
    endproperty
    a_param_store: assert property (p_param_store)
        else $error("scan parameter not stored");

    property p_unused_zero;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_reg.scan_orientation_control_reg &
            ~panel_cmd_pkg::SCAN_ORIENTATION_MASK) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused scan bits not zero");

    property p_frame_apply;
        @(posedge clk_i) disable iff (!rst_b_i)
        !frame_start_i |=> $stable(active);
    endproperty
    a_frame_apply: assert property (p_frame_apply)
        else $error("setting changed away from frame start");

    property p_blank_output;
        @(posedge clk_i) disable iff (!rst_b_i)
        !active[3] |=> blanked_o && pixel_o == 24'h000000;
    endproperty
    a_blank_output: assert property (p_blank_output)
        else $error("pixels passed while blanked");

    property p_wake_time;
        @(posedge clk_i) disable iff (!rst_b_i)
        state_reg.power == ST_SLEEP ##1 state_reg.power == ST_WAKING
        |-> (state_reg.power != ST_AWAKE &&
            state_reg.power != ST_WAKE_BLANK)[*8];
    endproperty
    a_wake_time: assert property (p_wake_time)
        else $error("wake sequence ended too early");
endmodule : display_gate_and_scan_control

/* sim/host_model.sv */
// host processor model sending command and parameter bytes
module host_model (
    input wire logic clk_i,
    output logic byte_valid_o,
    output logic cmd_param_sel_o,
    output logic [7:0] byte_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        byte_valid_o = 1'b0;
        cmd_param_sel_o = 1'b0;
        byte_o = 8'h00;
    end

    // ------------------------------------------------------------
    // byte transfer
    // ------------------------------------------------------------
    // one byte for one cycle; released data shows its inverse
    task automatic send(input logic sel, input logic [7:0] b);
        @(negedge clk_i);
        byte_valid_o = 1'b1;
        cmd_param_sel_o = sel;
        byte_o = b;
        @(negedge clk_i);
        byte_valid_o = 1'b0;
        byte_o = ~b;
    endtask : send
endmodule : host_model

/* sim/tb.sv */
// testbench for the panel command decoder
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WAKE = 20;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic byte_valid, sel, blanked, filt, src, gate, awake;
    logic frame_start = 1'b0;
    logic [7:0] byte_v;
    logic [23:0] pixel_in = 24'h5a3c81;
    logic [23:0] pixel_out;
    logic [3:0] st;
    logic [7:0] tbl [5] = '{8'h08, 8'h02, 8'h01, 8'hf4, 8'hff};
    int fails = 0;
    int comparisons = 0;

    always #20 clk_i = ~clk_i;
    assign st = {blanked, filt, src, gate};

    host_model u_host (
        .clk_i(clk_i),
        .byte_valid_o(byte_valid),
        .cmd_param_sel_o(sel),
        .byte_o(byte_v)
    );

    display_gate_and_scan_control #(.WAKE_CYCLES(WAKE)) uut (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .byte_valid_i(byte_valid),
        .cmd_param_sel_i(sel),
        .byte_i(byte_v),
        .frame_start_i(frame_start),
        .pixel_i(pixel_in),
        .pixel_o(pixel_out),
        .blanked_o(blanked),
        .filter_order_sel_o(filt),
        .source_dir_sel_o(src),
        .gate_dir_sel_o(gate),
        .awake_o(awake)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic frame();
        @(negedge clk_i);
        frame_start = 1'b1;
        @(negedge clk_i);
        frame_start = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask : frame

    task automatic cmd(input logic [7:0] c);
        u_host.send(1'b0, c);
        frame();
    endtask : cmd

    task automatic wake();
        int n;
        u_host.send(1'b0, panel_cmd_pkg::WAKE_CMD);
        repeat (WAKE + 2) @(negedge clk_i);
        frame();
        frame();
        chk("awake early", awake, 1'b0);
        n = 0;
        while (awake !== 1'b1 && n < 10) begin
            frame();
            n++;
        end
        if (awake !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask : wake

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk_i);
        rst_b_i = 1'b1;
        chk("reset state", st, 4'h8);
        chk("reset pixel", pixel_out, 24'h000000);
        wake();
        chk("awake", awake, 1'b1);
        chk("blank after wake", blanked, 1'b1);
        u_host.send(1'b0, panel_cmd_pkg::UNBLANK_PANEL_CMD);
        chk("on pending", blanked, 1'b1);
        frame();
        chk("on state", st, 4'h0);
        chk("on pixel", pixel_out, pixel_in);
        cmd(panel_cmd_pkg::UNBLANK_PANEL_CMD);
        chk("on twice", st, 4'h0);
        foreach (tbl[i]) begin
            u_host.send(1'b0, panel_cmd_pkg::SCAN_ORIENTATION_CMD);
            u_host.send(1'b1, tbl[i]);
            chk("scan pending", st[2:0], 3'h0);
            frame();
            chk("scan", st, {1'b0, tbl[i][3], tbl[i][1:0]});
            u_host.send(1'b0, panel_cmd_pkg::SCAN_ORIENTATION_CMD);
            u_host.send(1'b1, 8'h00);
            frame();
        end
        u_host.send(1'b0, panel_cmd_pkg::SCAN_ORIENTATION_CMD);
        u_host.send(1'b1, 8'hfb);
        frame();
        chk("scan bits", st, 4'h7);
        // orphan parameter, then a parameter cancelled by a command
        u_host.send(1'b1, 8'h00);
        u_host.send(1'b0, panel_cmd_pkg::SCAN_ORIENTATION_CMD);
        u_host.send(1'b0, panel_cmd_pkg::BLANK_PANEL_CMD);
        u_host.send(1'b1, 8'h00);
        frame();
        chk("off state", st, 4'hf);
        chk("off pixel", pixel_out, 24'h000000);
        cmd(panel_cmd_pkg::BLANK_PANEL_CMD);
        chk("off twice", st, 4'hf);
        cmd(panel_cmd_pkg::UNBLANK_PANEL_CMD);
        chk("on keeps scan", st, 4'h7);
        cmd(panel_cmd_pkg::SOFT_RESET_CMD);
        chk("soft reset", st, 4'hf);
        chk("soft reset sleep", awake, 1'b0);
        wake();
        chk("soft reset off", blanked, 1'b1);
        rst_b_i = 1'b0;
        @(negedge clk_i);
        rst_b_i = 1'b1;
        chk("hard reset", st, 4'h8);
        frame();
        chk("hard reset scan", st, 4'h8);
        give_verdict();
    end
endmodule : tb
